// ==== hdl/fsp_pkg.sv ====
// Operation
// - Block frequency evaluation while all three line voltages are below minimum.
// - In step modes raise alarm at once when any phase passes pickup, unblocked.
// - Start the supervision interval timer together with that alarm.
// - Trip when, inside the interval, pickup holds and the change reaches the step.
// - No trip when the interval ends before the change reaches the step.
// - After a trip-less interval stay inhibited until pickup is newly crossed.
// - Over variant counts rise, under variant counts fall, compared as magnitude.
// - Start a new cycle-duration measurement at every zero crossing.
// - Compare cycle duration with a reference; early or late gives the angle.
// - Trip immediately, without delay, when the surge angle exceeds threshold.
// - Suppress surge tripping while any measuring phase is lost.
// - Setting chooses whether three, two or one phase must exceed.
// - When the phase condition holds and unblocked, raise alarm and trip together.
// - Surge detection must recognise mains failure within 60 ms.
// - Block surge measurement at low voltage, faster than a surge trip.
// - Slow frequency drift must not cause a trip.
package fsp_pkg;
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DETECT_MS     = 60;
  // Widths
  localparam int unsigned FW = 16;
  localparam int unsigned CW = 20;
  localparam int unsigned PW = 40;
  localparam int unsigned REF_SHIFT = 4;
  localparam logic [PW-1:0] ANG_FULL = 40'h0000000e10;  // Tenths of degree per cycle
  localparam logic [CW-1:0] CNT_MAX  = 20'hfffff;
  // Register offsets
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_PICKUP   = 12'h004;
  localparam logic [11:0] OFS_STEP     = 12'h008;
  localparam logic [11:0] OFS_INTERVAL = 12'h00c;
  localparam logic [11:0] OFS_UV       = 12'h010;
  localparam logic [11:0] OFS_SURGE    = 12'h014;
  localparam logic [11:0] OFS_STATUS   = 12'h018;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h01c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
  localparam logic [11:0] OFS_DEV      = 12'h024;
  // Control fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SEL_LSB  = 2;
  localparam int unsigned CTRL_BLOCK    = 4;
  localparam int unsigned CTRL_ACK      = 5;
  // Modes and phase selections
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_UNDER = 2'h1;
  localparam logic [1:0] MODE_OVER  = 2'h2;
  localparam logic [1:0] MODE_SURGE = 2'h3;
  localparam logic [1:0] SEL_ALL = 2'h0;
  localparam logic [1:0] SEL_TWO = 2'h1;
  localparam logic [1:0] SEL_ONE = 2'h2;
  // Interrupt bits
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_TRIP  = 1;
  localparam int unsigned IRQ_EXPIRE = 2;
  localparam int unsigned IRQ_BLOCK = 3;
  // Reset values
  localparam logic [5:0]    CTRL_RST     = 6'h00;
  localparam logic [FW-1:0] PICKUP_RST   = 16'h0000;
  localparam logic [FW-1:0] STEP_RST     = 16'hffff;
  localparam logic [FW-1:0] INTERVAL_RST = 16'h0064;
  localparam logic [FW-1:0] UV_RST       = 16'h0000;
  localparam logic [FW-1:0] SURGE_RST    = 16'h0064;
  // Frequency step states
  typedef enum logic [3:0] {
    FS_ARMED = 4'b0001,
    FS_RUN   = 4'b0010,
    FS_TRIP  = 4'b0100,
    FS_INHIB = 4'b1000
  } fsp_state_t;
endpackage : fsp_pkg

// ==== hdl/fsp_top.sv ====
`timescale 1ns/100ps
module fsp_top import fsp_pkg::*; #(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  // Measurement front end
  input  wire logic [FW-1:0] line_voltage_ab,
  input  wire logic [FW-1:0] line_voltage_bc,
  input  wire logic [FW-1:0] line_voltage_ca,
  input  wire logic [FW-1:0] freq_ab,
  input  wire logic [FW-1:0] freq_bc,
  input  wire logic [FW-1:0] freq_ca,
  input  wire logic [2:0]    zero_cross,
  input  wire logic [2:0]    phase_lost,
  input  wire logic          block_cmd,
  // Protection outputs
  output logic               alarm,
  output logic               trip,
  output logic               irq
);

  // Registers
  logic [5:0]       ctrl_r;
  logic [FW-1:0]    pickup_r, step_r, interval_r, uv_r, surge_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [11:0]      addr_r;
  logic             wr_pend_r, rd_pend_r, rd_done_r;
  logic [31:0]      hrdata_r;
  fsp_state_t       state_r, state_nxt;
  logic [FW-1:0]    ref_f_r, timer_r;
  logic [31:0]      tick_cnt_r;
  logic             pick_q_r, alarm_r, trip_r, surge_lat_r, fblk_q_r;
  logic [CW-1:0]    dev_last_r;

  // Bus decode
  wire        take    = hsel & htrans[1] & hready;
  wire        rd_wait = rd_pend_r & ~rd_done_r;
  wire        wr_en   = wr_pend_r;
  wire        wr_ctrl = wr_en & (addr_r == OFS_CTRL);
  wire        wr_pick = wr_en & (addr_r == OFS_PICKUP);
  wire        wr_step = wr_en & (addr_r == OFS_STEP);
  wire        wr_intv = wr_en & (addr_r == OFS_INTERVAL);
  wire        wr_uv   = wr_en & (addr_r == OFS_UV);
  wire        wr_surg = wr_en & (addr_r == OFS_SURGE);
  wire        wr_istat = wr_en & (addr_r == OFS_IRQ_STAT);
  wire        wr_imask = wr_en & (addr_r == OFS_IRQ_MASK);
  wire        ack     = wr_ctrl & hwdata[CTRL_ACK];
  wire [1:0]  mode    = ctrl_r[CTRL_MODE_LSB +: 2];
  wire [1:0]  sel     = ctrl_r[CTRL_SEL_LSB +: 2];
  wire        blk     = ctrl_r[CTRL_BLOCK] | block_cmd;
  assign hreadyout = ~rd_wait;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Bus phase tracking
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r    <= 12'h000;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_done_r <= 1'b0;
    end else begin
      if (take) addr_r <= haddr[11:0];
      wr_pend_r <= take & hwrite;
      rd_pend_r <= rd_wait | (take & ~hwrite);
      rd_done_r <= rd_wait;
    end
  end

  // Voltage lockouts
  wire [2:0] v_low;
  assign v_low[0] = line_voltage_ab < uv_r;
  assign v_low[1] = line_voltage_bc < uv_r;
  assign v_low[2] = line_voltage_ca < uv_r;
  wire freq_blk = &v_low;
  wire any_low  = |v_low;

  // Frequency pickup and step magnitude
  wire        over      = mode == MODE_OVER;
  wire        step_mode = (mode == MODE_UNDER) | over;
  wire [FW-1:0] fmin_ab = (freq_ab < freq_bc) ? freq_ab : freq_bc;
  wire [FW-1:0] fmax_ab = (freq_ab > freq_bc) ? freq_ab : freq_bc;
  wire [FW-1:0] fmin    = (fmin_ab < freq_ca) ? fmin_ab : freq_ca;
  wire [FW-1:0] fmax    = (fmax_ab > freq_ca) ? fmax_ab : freq_ca;
  wire [FW-1:0] fext    = over ? fmax : fmin;
  wire        pick_any  = over ? (fmax > pickup_r) : (fmin < pickup_r);
  wire        pickup    = step_mode & pick_any & ~freq_blk & ~blk;
  wire        moved     = over ? (fext > ref_f_r) : (fext < ref_f_r);
  wire [FW-1:0] delta   = over ? fext - ref_f_r : ref_f_r - fext;
  wire        step_hit  = moved & (delta >= step_r);
  wire        tick      = tick_cnt_r == TICK_LEN - 1;
  wire        expired   = (state_r == FS_RUN) & (timer_r == '0);
  wire        new_cross = pickup & ~pick_q_r;

  // Frequency step sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FS_ARMED: if (pickup) state_nxt = FS_RUN;
      FS_RUN: begin
        if (!pickup) state_nxt = FS_ARMED;
        else if (step_hit) state_nxt = FS_TRIP;
        else if (expired) state_nxt = FS_INHIB;
      end
      FS_TRIP:  if (!pickup) state_nxt = FS_ARMED;
      FS_INHIB: if (new_cross) state_nxt = FS_RUN;
      default:  state_nxt = FS_ARMED;
    endcase
    if (!step_mode) state_nxt = FS_ARMED;
  end

  wire start_run = (state_nxt == FS_RUN) & (state_r != FS_RUN);

  // Sequence state, interval timer and reference frequency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= FS_ARMED;
      tick_cnt_r <= 32'h00000000;
      timer_r    <= '0;
      ref_f_r    <= '0;
      pick_q_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      pick_q_r   <= pickup;
      tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
      if (start_run) begin
        timer_r <= interval_r;
        ref_f_r <= fext;
      end else if (tick && timer_r != '0) begin
        timer_r <= timer_r - 1'b1;
      end
    end
  end

  // Vector surge, one channel per phase
  wire             surge_mode = mode == MODE_SURGE;
  wire             surge_rst  = ~surge_mode | any_low;
  logic [2:0]      hit;
  logic [CW-1:0]   dev_w [3];

  for (genvar i = 0; i < 3; i++) begin : g_ph
    logic [CW-1:0] cnt_r, ref_r;
    logic          refv_r, hit_r, seen_r;
    wire  [CW-1:0] dev   = (cnt_r >= ref_r) ? cnt_r - ref_r : ref_r - cnt_r;
    wire  [PW-1:0] lhs   = PW'(dev) * ANG_FULL;
    wire  [PW-1:0] rhs   = PW'(surge_r) * PW'(ref_r);
    wire           exceed = refv_r & (lhs > rhs);
    wire signed [CW:0] diff = $signed({1'b0, cnt_r}) - $signed({1'b0, ref_r});
    wire signed [CW:0] corr = diff >>> REF_SHIFT;
    assign dev_w[i] = dev;
    assign hit[i]   = hit_r;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_r  <= '0;
        ref_r  <= '0;
        refv_r <= 1'b0;
        hit_r  <= 1'b0;
        seen_r <= 1'b0;
      end else if (surge_rst || phase_lost[i]) begin
        cnt_r  <= '0;
        refv_r <= 1'b0;
        hit_r  <= 1'b0;
        seen_r <= 1'b0;
      end else if (zero_cross[i]) begin
        cnt_r  <= {{(CW-1){1'b0}}, 1'b1};
        seen_r <= 1'b1;
        hit_r  <= exceed;
        if (!refv_r) begin
          // A partial count since arming must never become the reference
          if (seen_r) begin
            ref_r  <= cnt_r;
            refv_r <= 1'b1;
          end
        end else if (!exceed) begin
          ref_r <= ref_r + corr[CW-1:0];
        end
      end else if (cnt_r == CNT_MAX) begin
        refv_r <= 1'b0;
        seen_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Phase count selection
  wire [1:0] n_hit = {1'b0, hit[0]} + {1'b0, hit[1]} + {1'b0, hit[2]};
  wire [1:0] need  = (sel == SEL_ONE) ? 2'h1 : (sel == SEL_TWO) ? 2'h2 : 2'h3;
  wire surge_go = surge_mode & (n_hit >= need) & ~|phase_lost & ~any_low & ~blk;

  // Output and interrupt events
  wire             lat_nxt   = surge_go | (surge_lat_r & surge_mode & ~ack);
  wire             alarm_nxt = pickup | lat_nxt;
  wire             trip_nxt  = (state_nxt == FS_TRIP) | lat_nxt;
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_ALARM]  = alarm_nxt & ~alarm_r;
  assign ev[IRQ_TRIP]   = trip_nxt & ~trip_r;
  assign ev[IRQ_EXPIRE] = (state_r == FS_RUN) & (state_nxt == FS_INHIB);
  assign ev[IRQ_BLOCK]  = freq_blk & ~fblk_q_r;
  wire [IRQ_W-1:0] clr = wr_istat ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_r     <= 1'b0;
      trip_r      <= 1'b0;
      surge_lat_r <= 1'b0;
      fblk_q_r    <= 1'b0;
      irq_stat_r  <= '0;
      dev_last_r  <= '0;
    end else begin
      alarm_r     <= alarm_nxt;
      trip_r      <= trip_nxt;
      surge_lat_r <= lat_nxt;
      fblk_q_r    <= freq_blk;
      irq_stat_r  <= (irq_stat_r & ~clr) | ev;  // Set wins over clear
      if (zero_cross[0]) dev_last_r <= dev_w[0];
    end
  end

  assign alarm = alarm_r;
  assign trip  = trip_r;
  assign irq   = |(irq_stat_r & irq_mask_r);

  // Software settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r     <= CTRL_RST;
      pickup_r   <= PICKUP_RST;
      step_r     <= STEP_RST;
      interval_r <= INTERVAL_RST;
      uv_r       <= UV_RST;
      surge_r    <= SURGE_RST;
      irq_mask_r <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= {1'b0, hwdata[CTRL_BLOCK:0]};
      if (wr_pick) pickup_r <= hwdata[FW-1:0];
      if (wr_step) step_r <= hwdata[FW-1:0];
      if (wr_intv) interval_r <= hwdata[FW-1:0];
      if (wr_uv) uv_r <= hwdata[FW-1:0];
      if (wr_surg) surge_r <= hwdata[FW-1:0];
      if (wr_imask) irq_mask_r <= hwdata[IRQ_W-1:0];
    end
  end

  // Read mux
  wire [31:0] status = {21'h0, hit, any_low, freq_blk, trip_r, alarm_r, state_r};
  wire [31:0] rd_mux =
    (addr_r == OFS_CTRL)     ? {26'h0, ctrl_r} :
    (addr_r == OFS_PICKUP)   ? {16'h0, pickup_r} :
    (addr_r == OFS_STEP)     ? {16'h0, step_r} :
    (addr_r == OFS_INTERVAL) ? {16'h0, interval_r} :
    (addr_r == OFS_UV)       ? {16'h0, uv_r} :
    (addr_r == OFS_SURGE)    ? {16'h0, surge_r} :
    (addr_r == OFS_STATUS)   ? status :
    (addr_r == OFS_IRQ_STAT) ? {28'h0, irq_stat_r} :
    (addr_r == OFS_IRQ_MASK) ? {28'h0, irq_mask_r} :
    (addr_r == OFS_DEV)      ? {12'h0, dev_last_r} : 32'h00000000;

  // Read data capture during the wait cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hrdata_r <= 32'h00000000;
    else if (rd_wait) hrdata_r <= rd_mux;
  end

endmodule : fsp_top

// ==== verification/fsp_top_asserts.sv ====
`timescale 1ns/100ps
module fsp_top_asserts import fsp_pkg::*; #(
  parameter int unsigned TICK_LEN = 10
) (
  // Clock, reset and bus
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic          hresp,
  // Measurements and outputs
  input wire logic [FW-1:0] line_voltage_ab,
  input wire logic [FW-1:0] line_voltage_bc,
  input wire logic [FW-1:0] line_voltage_ca,
  input wire logic [FW-1:0] freq_ab,
  input wire logic [FW-1:0] freq_bc,
  input wire logic [FW-1:0] freq_ca,
  input wire logic [2:0]    zero_cross,
  input wire logic [2:0]    phase_lost,
  input wire logic          block_cmd,
  input wire logic          alarm,
  input wire logic          trip
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic          wr_r;
  logic [11:0]   a_r;
  logic [4:0]    ctrl_r;
  logic [FW-1:0] pick_r;
  logic [FW-1:0] uv_r;
  // Shadow copy of the control, pickup and undervoltage settings written over the bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r   <= 1'b0;
      a_r    <= 12'h000;
      ctrl_r <= 5'h00;
      pick_r <= PICKUP_RST;
      uv_r   <= UV_RST;
    end else if (hready) begin
      wr_r <= hsel & htrans[1] & hwrite;
      a_r  <= haddr[11:0];
      if (wr_r && a_r == OFS_CTRL) ctrl_r <= hwdata[4:0];
      if (wr_r && a_r == OFS_PICKUP) pick_r <= hwdata[FW-1:0];
      if (wr_r && a_r == OFS_UV) uv_r <= hwdata[FW-1:0];
    end
  end
  // Decoded mode, blocking and pickup condition
  wire       under_m = ctrl_r[1:0] == MODE_UNDER;
  wire       step_m  = under_m || ctrl_r[1:0] == MODE_OVER;
  wire       surge_m = ctrl_r[1:0] == MODE_SURGE;
  wire       off_m   = ctrl_r[1:0] == MODE_OFF;
  wire       blk     = block_cmd | ctrl_r[CTRL_BLOCK];
  wire [2:0] low = {line_voltage_ca < uv_r, line_voltage_bc < uv_r, line_voltage_ab < uv_r};
  wire [2:0] dn  = {freq_ca < pick_r, freq_bc < pick_r, freq_ab < pick_r};
  wire [2:0] up  = {freq_ca > pick_r, freq_bc > pick_r, freq_ab > pick_r};
  wire       all_low = &low;
  wire       pick = step_m && !blk && !all_low && (under_m ? |dn : |up);
  wire       s_off = |phase_lost || |low;
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_RD_WAIT: assert property (hsel && htrans[1] && !hwrite && hready |=> rd_wait)
    else $error("read wait cycle wrong");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  AST_STEP_ALARM: assert property ($rose(pick) |-> ##[1:2] alarm)
    else $error("step alarm late");
  AST_UV_BLOCK: assert property (step_m && all_low && $past(all_low) |-> !$rose(alarm))
    else $error("alarm while voltages low");
  AST_STEP_TRIP: assert property (step_m && $rose(trip) |-> $past(pick))
    else $error("step trip without pickup");
  AST_SURGE_PAIR: assert property (surge_m && $rose(trip) |-> $rose(alarm) && $past(|zero_cross, 2))
    else $error("surge trip not paired with crossing");
  AST_SURGE_LOST: assert property (surge_m && $past(s_off) |-> !$rose(trip))
    else $error("surge trip with lost phase");
  AST_BLOCK: assert property ($past(blk) |-> !$rose(alarm) && !$rose(trip))
    else $error("output rose while blocked");
  AST_OFF: assert property (off_m && $past(off_m) |-> !$rose(trip))
    else $error("trip in off mode");
endmodule : fsp_top_asserts

bind fsp_top fsp_top_asserts #(.TICK_LEN(TICK_LEN)) u_fsp_top_asserts (
  .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .line_voltage_ab(line_voltage_ab), .line_voltage_bc(line_voltage_bc),
  .line_voltage_ca(line_voltage_ca), .freq_ab(freq_ab), .freq_bc(freq_bc), .freq_ca(freq_ca),
  .zero_cross(zero_cross), .phase_lost(phase_lost), .block_cmd(block_cmd), .alarm(alarm),
  .trip(trip));

// ==== verification/fsp_front.sv ====
`timescale 1ns/100ps
module fsp_front (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Crossing control
  input  wire logic [15:0]        period,
  input  wire logic [2:0]         jump_mask,
  input  wire logic signed [15:0] jump_dly,
  input  wire logic               jump_req,
  // Crossing pulses
  output logic [2:0]              zero_cross
);
  int cnt [3];
  // One crossing a period per phase; a jump moves the next one later or earlier
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt        <= '{0, 0, 0};
      zero_cross <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        zero_cross[i] <= cnt[i] >= int'(period) - 1;
        if (cnt[i] >= int'(period) - 1) cnt[i] <= 0;
        else if (jump_req && jump_mask[i]) cnt[i] <= cnt[i] + 1 - int'(jump_dly);
        else cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : fsp_front

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench import fsp_pkg::*; ;
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, block_cmd = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [FW-1:0] vab = 16'h07d0, fab_v = 16'h13ec, fbc = 16'h13ec, fca = 16'h13ec;
  logic [2:0] phase_lost = 3'h0, jmask = 3'h0;
  logic [15:0] period = 16'h00c8, jdly = 16'h0000;
  logic jreq = 1'b0;
  wire hreadyout, hresp, alarm, trip, irq;
  wire [31:0] hrdata;
  wire [2:0] zc;
  int error_cnt = 0, checked = 0;
  typedef struct packed {logic [5:0] c; logic [2:0] m; logic [15:0] d; logic [2:0] l; logic e;} fsp_row_t;
  // Surge cases: control, jumped phases, shift, lost phases, trip expected
  fsp_row_t rows [7] = '{'{6'h2b, 3'h1, 16'h003c, 3'h0, 1'b1}, '{6'h2b, 3'h1, 16'hffc4, 3'h0, 1'b1},
    '{6'h23, 3'h1, 16'h003c, 3'h0, 1'b0}, '{6'h23, 3'h7, 16'h003c, 3'h0, 1'b1},
    '{6'h27, 3'h3, 16'h003c, 3'h0, 1'b1}, '{6'h27, 3'h1, 16'h003c, 3'h0, 1'b0},
    '{6'h2b, 3'h1, 16'h003c, 3'h1, 1'b0}};
  logic [43:0] regs [9] = '{{OFS_CTRL, 32'h0}, {OFS_PICKUP, 32'h0}, {OFS_STEP, 32'hffff},
    {OFS_INTERVAL, 32'h64}, {OFS_UV, 32'h0}, {OFS_SURGE, 32'h64}, {OFS_IRQ_STAT, 32'h0},
    {OFS_IRQ_MASK, 32'h0}, {12'h040, 32'h0}};
  always #12.5 clk = ~clk;
  fsp_top #(.TICK_LEN(10)) u_fsp_top (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .line_voltage_ab(vab),
    .line_voltage_bc(16'h07d0), .line_voltage_ca(16'h07d0), .freq_ab(fab_v), .freq_bc(fbc),
    .freq_ca(fca), .zero_cross(zc), .phase_lost(phase_lost), .block_cmd(block_cmd),
    .alarm(alarm), .trip(trip), .irq(irq));
  fsp_front u_fsp_front (.clk(clk), .arst_n(arst_n), .period(period), .jump_mask(jmask),
    .jump_dly(jdly), .jump_req(jreq), .zero_cross(zc));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One single AHB-Lite transfer; read data taken in the ready cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic r;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do begin @(negedge clk); r = hreadyout; @(posedge clk); end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(negedge clk); r = hreadyout; rd = hrdata; @(posedge clk); end while (r !== 1'b1);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask : rdc
  // Sets phase ab frequency and blocking, then waits n edges
  task automatic fab(input logic [15:0] v, input logic b, input int n);
    @(posedge clk);
    fab_v <= v;
    block_cmd <= b;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : fab
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #1ms;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    chk("trip in reset", {alarm, trip, irq, hreadyout}, 32'h1);
    arst_n <= 1'b1;
    foreach (regs[i]) rdc("reset value", regs[i][43:32], regs[i][31:0]);
    wr(12'h040, 32'hffffffff);
    rdc("unmapped", 12'h040, 32'h0);
    wr(OFS_PICKUP, 32'h1388);
    wr(OFS_STEP, 32'h0064);
    wr(OFS_INTERVAL, 32'h0003);
    wr(OFS_UV, 32'h0bb8);
    wr(OFS_IRQ_MASK, 32'h2);
    wr(OFS_CTRL, {30'h0, MODE_UNDER});
    fab(16'h137e, 1'b0, 3);
    chk("alarm all low", alarm, 1'b0);
    rdc("status blocked", OFS_STATUS, 32'h000000c1);
    rdc("block flag", OFS_IRQ_STAT, 32'h00000008);
    fab(16'h13ec, 1'b0, 2);
    wr(OFS_UV, 32'h03e8);
    fab(16'h137e, 1'b1, 3);
    chk("alarm blocked", alarm, 1'b0);
    fab(16'h13ec, 1'b0, 2);
    fab(16'h137e, 1'b0, 2);
    chk("alarm", {alarm, trip}, 32'h2);
    fab(16'h1310, 1'b0, 2);
    chk("step trip", {trip, irq}, 32'h3);
    wr(OFS_IRQ_STAT, 32'hf);
    @(negedge clk);
    chk("irq cleared", irq, 1'b0);
    fab(16'h13ec, 1'b0, 2);
    chk("trip drop", trip, 1'b0);
    fab(16'h137e, 1'b0, 50);
    chk("no trip expired", trip, 1'b0);
    rdc("expired flag", OFS_IRQ_STAT, 32'h5);
    fab(16'h12c0, 1'b0, 5);
    chk("inhibited", trip, 1'b0);
    fab(16'h13ec, 1'b0, 2);
    fab(16'h137e, 1'b0, 3);
    fab(16'h1310, 1'b0, 2);
    chk("rearmed trip", trip, 1'b1);
    @(posedge clk);
    fbc <= 16'h1324;
    fca <= 16'h1324;
    fab(16'h1324, 1'b0, 2);
    wr(OFS_CTRL, {30'h0, MODE_OVER});
    fab(16'h14b4, 1'b0, 3);
    fab(16'h141e, 1'b0, 3);
    chk("over fall", {alarm, trip}, 32'h2);
    fab(16'h152c, 1'b0, 2);
    chk("over rise", trip, 1'b1);
    fab(16'h1324, 1'b0, 2);
    wr(OFS_CTRL, 32'h2b);
    repeat (1000) @(posedge clk);
    for (int p = 201; p < 204; p++) begin
      period <= p[15:0];
      repeat (600) @(posedge clk);
    end
    chk("drift", trip, 1'b0);
    period <= 16'h00c8;
    repeat (600) @(posedge clk);
    foreach (rows[i]) begin
      // Let the previous jump settle so every hit flag has cleared before the ack
      @(posedge clk);
      phase_lost <= rows[i].l;
      repeat (500) @(negedge clk);
      wr(OFS_CTRL, {26'h0, rows[i].c});
      while (zc[0] !== 1'b1) @(negedge clk);
      chk("surge idle", {alarm, trip}, 32'h0);
      @(posedge clk);
      jmask <= rows[i].m;
      jdly <= rows[i].d;
      jreq <= 1'b1;
      @(posedge clk);
      jreq <= 1'b0;
      for (int k = 0; k < 300 && trip !== 1'b1; k++) @(negedge clk);
      chk("surge trip", trip, rows[i].e);
      chk("surge alarm", alarm, rows[i].e);
    end
    // Reset again in mid-run: outputs and settings return to reset values
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk("outputs in reset", {alarm, trip, irq, hreadyout}, 32'h1);
    @(posedge clk);
    arst_n <= 1'b1;
    rdc("ctrl after reset", OFS_CTRL, 32'h0);
    rdc("uv after reset", OFS_UV, 32'h0);
    print_verdict();
  end
endmodule : testbench
